// ===== core/tsd_regs.sv
// Operation
// [RL1] Every register is reached by status read and write, selected by register number.
// [RL2] Boot status is read-only: processor number, override, core1 off, poll, RAM, JTAG, PLL.
// [RL3] Setting security bit 31 blocks every later software write to that register.
// [RL4] Security bits 14, 4 and 0 disable global debug, JTAG config and JTAG TAP.
// [RL5] Security bits 12, 11:8, 7, 5 lock OTP, lock sectors, redundancy, boot override.
// [RL6] The security register is loaded as a copy of the OTP security word.
// [RL7] Four free-running oscillators each clock a counter, started and stopped by control.
// [RL8] Control bit 1 enables core, bit 0 peripheral oscillators; both reset to zero.
// [RL9] Software reads a count only after the oscillator stopped ten clocks.
// [RL10] Registers 0x07 to 0x0a return core cell, core wire, peripheral cell, wire counts.
// [RL11] Oscillator counts survive a system reset.
// [RL12] Oscillators run asynchronously to the tile clock, giving random bits.
// [RL13] RAM size reads bytes in bits 31:2, bits 1:0 reserved, read-only.
// [RL14] Saved status keeps address space, issue modes, fast and paused bits from entry.
// [RL15] Saved status also keeps kernel, interrupt, event sequence, interrupt and event enables.
// [RL16] Saved program counter holds the full 32-bit value from debugger entry.
// [RL17] Saved stack pointer holds the full 32-bit value from debugger entry.
// [RL18] Thread select operand holds the logical core number in bits 7:0.
// [RL19] Register select operand holds the register number in bits 4:0.
// [RL20] Reserved bits read as zero and ignore writes.
`timescale 1ns/100ps
module tsd_regs
  import tsd_pkg::*;
#(
  parameter logic [31:0] RAM_BYTES = 32'h0001_0000
)
(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        PS_RD,
  input  wire logic        PS_WR,
  input  wire logic [7:0]  PS_ADDR,
  input  wire logic [31:0] PS_WDATA,
  output logic [31:0]      PS_RDATA,
  output logic             PS_RVALID,
  output logic             PS_ERR,
  input  wire logic [7:0]  BOOT_PROC_NUM,
  input  wire logic        BOOT_OVERRIDE,
  input  wire logic        BOOT_CORE1_OFF,
  input  wire logic        BOOT_SKIP_POLL,
  input  wire logic        BOOT_FROM_RAM,
  input  wire logic        BOOT_FROM_JTAG,
  input  wire logic [1:0]  BOOT_PLL_MODE,
  input  wire logic        OTP_SEC_VALID,
  input  wire logic [31:0] OTP_SEC_WORD,
  input  wire logic [3:0]  RO_TICK,
  input  wire logic        DBG_MODE,
  input  wire logic        DBG_ENTRY,
  input  wire logic [31:0] THREAD_SR,
  input  wire logic [31:0] THREAD_PC,
  input  wire logic [31:0] THREAD_SP,
  output logic             SEC_LOCKED,
  output logic             DBG_GLOBAL_DIS,
  output logic             JTAG_CFG_DIS,
  output logic             JTAG_TAP_DIS,
  output logic             OTP_LOCK_ALL,
  output logic [3:0]       OTP_SECTOR_LOCK,
  output logic             OTP_REDUNDANCY_EN,
  output logic             OTP_BOOT_OVERRIDE,
  output logic             RO_CORE_EN,
  output logic             RO_PERI_EN
);

  if (RAM_BYTES[1:0] != 2'b00)
  begin : g_bad_ram_bytes
    $error("RAM_BYTES must be a multiple of four");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [31:0] tsd_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [31:0] mask);
    tsd_merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  function automatic logic [31:0] tsd_count_word(input logic [15:0] cnt);
    tsd_count_word = {16'h0000, cnt};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic [31:0] boot_q;
  logic        boot_cap_q;
  logic [31:0] sec_q;
  logic [31:0] sec_d;
  logic [31:0] roc_q;
  logic [31:0] roc_d;
  logic [31:0] sts_q;
  logic [31:0] sts_d;
  logic [31:0] pc_q;
  logic [31:0] pc_d;
  logic [31:0] sp_q;
  logic [31:0] sp_d;
  logic [31:0] thr_q;
  logic [31:0] thr_d;
  logic [31:0] rnum_q;
  logic [31:0] rnum_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        rvalid_q;
  logic        err_q;
  logic        err_d;
  tsd_acc_t    acc;

  tsd_ro_if ro ();

  tsd_ring_osc u_osc
  (
    .CLK  (CLK),
    .NRST (NRST),
    .ro   (ro.osc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  wire hit_boot  = (PS_ADDR == TSD_REG_BOOT_STATUS);
  wire hit_sec   = (PS_ADDR == TSD_REG_SECURITY);
  wire hit_roc   = (PS_ADDR == TSD_REG_RO_CONTROL);
  wire hit_cnt0  = (PS_ADDR == TSD_REG_RO_CORE_CELL);
  wire hit_cnt1  = (PS_ADDR == TSD_REG_RO_CORE_WIRE);
  wire hit_cnt2  = (PS_ADDR == TSD_REG_RO_PERI_CELL);
  wire hit_cnt3  = (PS_ADDR == TSD_REG_RO_PERI_WIRE);
  wire hit_ram   = (PS_ADDR == TSD_REG_RAM_SIZE);
  wire hit_sts   = (PS_ADDR == TSD_REG_DBG_STATUS);
  wire hit_pc    = (PS_ADDR == TSD_REG_DBG_PC);
  wire hit_sp    = (PS_ADDR == TSD_REG_DBG_SP);
  wire hit_thr   = (PS_ADDR == TSD_REG_DBG_THREAD);
  wire hit_rnum  = (PS_ADDR == TSD_REG_DBG_REGNUM);
  wire hit_cnt   = hit_cnt0 | hit_cnt1 | hit_cnt2 | hit_cnt3;
  wire hit_dbg   = hit_sts | hit_pc | hit_sp | hit_thr | hit_rnum;
  wire hit_ro    = hit_boot | hit_cnt | hit_ram;
  wire hit_any   = hit_ro | hit_sec | hit_roc | hit_dbg;

  // A read wins when both strobes arrive together.
  assign acc = PS_RD ? TSD_ACC_READ : (PS_WR ? TSD_ACC_WRITE : TSD_ACC_NONE); // RL1

  wire sec_locked = sec_q[TSD_SEC_LOCK_BIT];
  wire wr_sec     = (acc == TSD_ACC_WRITE) && hit_sec && !sec_locked;       // RL3
  wire wr_roc     = (acc == TSD_ACC_WRITE) && hit_roc;
  // Debug registers accept software writes only while in debug mode.
  wire wr_dbg     = (acc == TSD_ACC_WRITE) && DBG_MODE;
  wire wr_refused = (acc == TSD_ACC_WRITE) && (hit_ro || (hit_sec && sec_locked) || (hit_dbg && !DBG_MODE));

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.

  wire [31:0] ram_word = RAM_BYTES & ~TSD_RAM_RSV_MASK; // RL13

  always_comb
  begin
    rdata_d = TSD_RST_WORD;
    if (hit_boot)
      rdata_d = boot_q;                         // RL2
    else if (hit_sec)
      rdata_d = sec_q;
    else if (hit_roc)
      rdata_d = roc_q;
    else if (hit_cnt0)
      rdata_d = tsd_count_word(ro.count[0]);    // RL10
    else if (hit_cnt1)
      rdata_d = tsd_count_word(ro.count[1]);    // RL10
    else if (hit_cnt2)
      rdata_d = tsd_count_word(ro.count[2]);    // RL10
    else if (hit_cnt3)
      rdata_d = tsd_count_word(ro.count[3]);    // RL10
    else if (hit_ram)
      rdata_d = ram_word;
    else if (hit_sts)
      rdata_d = sts_q;
    else if (hit_pc)
      rdata_d = pc_q;
    else if (hit_sp)
      rdata_d = sp_q;
    else if (hit_thr)
      rdata_d = thr_q;
    else if (hit_rnum)
      rdata_d = rnum_q;
  end

  assign err_d = ((acc != TSD_ACC_NONE) && !hit_any) || wr_refused;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state values.

  // The OTP copy is a hardware load and is not held off by the lock bit.
  assign sec_d  = OTP_SEC_VALID ? (OTP_SEC_WORD & TSD_SEC_MASK)             // RL6
                : wr_sec ? (PS_WDATA & TSD_SEC_MASK) : sec_q;               // RL3 RL20
  assign roc_d  = wr_roc ? (PS_WDATA & TSD_ROC_MASK) : roc_q;               // RL8 RL20

  // Capture on debugger entry beats a software write in the same cycle.
  assign sts_d  = DBG_ENTRY ? (THREAD_SR & TSD_STS_CAP_MASK)                // RL14 RL15
                : (wr_dbg && hit_sts) ? tsd_merge(sts_q, PS_WDATA, TSD_STS_WR_MASK) : sts_q;
  assign pc_d   = DBG_ENTRY ? THREAD_PC                                     // RL16
                : (wr_dbg && hit_pc) ? PS_WDATA : pc_q;
  assign sp_d   = DBG_ENTRY ? THREAD_SP                                     // RL17
                : (wr_dbg && hit_sp) ? PS_WDATA : sp_q;
  assign thr_d  = (wr_dbg && hit_thr) ? (PS_WDATA & TSD_THREAD_MASK) : thr_q;   // RL18 RL20
  assign rnum_d = (wr_dbg && hit_rnum) ? (PS_WDATA & TSD_REGNUM_MASK) : rnum_q; // RL19 RL20

  ////////////////////////////////////////////////////////////////////////////
  // Boot straps are caught once, on the first edge after reset release.

  wire [31:0] boot_word = {8'h00, BOOT_PROC_NUM, 7'h00, BOOT_OVERRIDE, 2'b00,
                           BOOT_CORE1_OFF, BOOT_SKIP_POLL, BOOT_FROM_RAM, BOOT_FROM_JTAG,
                           BOOT_PLL_MODE};

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      boot_q     <= TSD_RST_WORD;
      boot_cap_q <= 1'b0;
    end
    else if (!boot_cap_q)
    begin
      boot_q     <= boot_word; // RL2
      boot_cap_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      sec_q  <= TSD_RST_WORD;
      roc_q  <= TSD_RST_WORD;
      sts_q  <= TSD_RST_WORD;
      pc_q   <= TSD_RST_WORD;
      sp_q   <= TSD_RST_WORD;
      thr_q  <= TSD_RST_WORD;
      rnum_q <= TSD_RST_WORD;
    end
    else
    begin
      sec_q  <= sec_d;
      roc_q  <= roc_d;
      sts_q  <= sts_d;
      pc_q   <= pc_d;
      sp_q   <= sp_d;
      thr_q  <= thr_d;
      rnum_q <= rnum_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      rdata_q  <= TSD_RST_WORD;
      rvalid_q <= 1'b0;
      err_q    <= 1'b0;
    end
    else
    begin
      rdata_q  <= (acc == TSD_ACC_READ) ? rdata_d : rdata_q; // RL1
      rvalid_q <= (acc == TSD_ACC_READ);
      err_q    <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign ro.core_en = roc_q[TSD_ROC_CORE_EN]; // RL7
  assign ro.peri_en = roc_q[TSD_ROC_PERI_EN]; // RL7
  assign ro.tick    = RO_TICK;

  assign PS_RDATA          = rdata_q;
  assign PS_RVALID         = rvalid_q;
  assign PS_ERR            = err_q;
  assign SEC_LOCKED        = sec_locked;
  assign DBG_GLOBAL_DIS    = sec_q[TSD_SEC_GDBG_DIS];                   // RL4
  assign JTAG_CFG_DIS      = sec_q[TSD_SEC_JTAG_CFG_DIS];               // RL4
  assign JTAG_TAP_DIS      = sec_q[TSD_SEC_JTAG_TAP_DIS];               // RL4
  assign OTP_LOCK_ALL      = sec_q[TSD_SEC_OTP_LOCK_ALL];               // RL5
  assign OTP_SECTOR_LOCK   = sec_q[TSD_SEC_OTP_SECT_LSB +: 4];          // RL5
  assign OTP_REDUNDANCY_EN = sec_q[TSD_SEC_OTP_REDUND];                 // RL5
  assign OTP_BOOT_OVERRIDE = sec_q[TSD_SEC_OTP_BOOT];                   // RL5
  assign RO_CORE_EN        = roc_q[TSD_ROC_CORE_EN];
  assign RO_PERI_EN        = roc_q[TSD_ROC_PERI_EN];

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Cycles since the core oscillators stopped; it saturates so a long stop never wraps it.
  logic [3:0] stop_cnt_q;

  always_ff @(posedge CLK)
  begin
    if (!NRST || RO_CORE_EN)
      stop_cnt_q <= 4'h0;
    else if (stop_cnt_q != 4'(TSD_RO_STOP_CYCLES))
      stop_cnt_q <= stop_cnt_q + 4'h1;
  end

  a_read_latency: assert property (@(posedge CLK) disable iff (!NRST) // RL1
    PS_RD |=> PS_RVALID ##1 (!PS_RVALID || $past(PS_RD)))
    else $error("read answer not one cycle after request");

  a_boot_readonly: assert property (@(posedge CLK) disable iff (!NRST) // RL2
    boot_cap_q && PS_WR && !PS_RD && hit_boot |=> $stable(boot_q) && PS_ERR)
    else $error("boot status changed by a write");

  a_sec_lock: assert property (@(posedge CLK) disable iff (!NRST) // RL3
    sec_locked && PS_WR && !PS_RD && hit_sec && !OTP_SEC_VALID |=> $stable(sec_q) && PS_ERR)
    else $error("locked security register accepted a write");

  a_otp_copy: assert property (@(posedge CLK) disable iff (!NRST) // RL6
    OTP_SEC_VALID |=> sec_q == ($past(OTP_SEC_WORD) & TSD_SEC_MASK))
    else $error("security register is not the OTP copy");

  a_sec_disables: assert property (@(posedge CLK) disable iff (!NRST) // RL4
    OTP_SEC_VALID |=> JTAG_TAP_DIS == $past(OTP_SEC_WORD[0]) && DBG_GLOBAL_DIS == $past(OTP_SEC_WORD[14]))
    else $error("disable outputs do not follow the loaded word");

  a_otp_sectors: assert property (@(posedge CLK) disable iff (!NRST) // RL5
    OTP_SEC_VALID |=> OTP_SECTOR_LOCK == $past(OTP_SEC_WORD[11:8]) && OTP_LOCK_ALL == $past(OTP_SEC_WORD[12]))
    else $error("OTP lock outputs do not follow the loaded word");

  a_roc_reset: assert property (@(posedge CLK) // RL8
    !NRST |=> !RO_CORE_EN && !RO_PERI_EN)
    else $error("oscillator enables not cleared by reset");

  a_count_upper: assert property (@(posedge CLK) disable iff (!NRST) // RL10
    PS_RD && hit_cnt |=> PS_RDATA[31:16] == 16'h0000)
    else $error("count register upper half not zero");

  a_ram_size: assert property (@(posedge CLK) disable iff (!NRST) // RL13
    PS_RD && hit_ram |=> PS_RDATA == (RAM_BYTES & ~TSD_RAM_RSV_MASK))
    else $error("RAM size read wrong");

  a_status_capture: assert property (@(posedge CLK) disable iff (!NRST) // RL14
    DBG_ENTRY |=> sts_q == ($past(THREAD_SR) & TSD_STS_CAP_MASK))
    else $error("saved status not captured on entry");

  a_pc_sp_capture: assert property (@(posedge CLK) disable iff (!NRST) // RL16
    DBG_ENTRY |=> pc_q == $past(THREAD_PC) && sp_q == $past(THREAD_SP))
    else $error("saved pc or sp not captured on entry");

  a_select_reserved: assert property (@(posedge CLK) disable iff (!NRST) // RL18
    PS_RD && (hit_thr || hit_rnum) |=> PS_RDATA[31:8] == 24'h000000)
    else $error("select operand reserved bits not zero");

  a_dbg_guard: assert property (@(posedge CLK) disable iff (!NRST) // RL20
    PS_WR && !PS_RD && hit_pc && !DBG_MODE && !DBG_ENTRY |=> $stable(pc_q))
    else $error("debug register written outside debug mode");

  c_lock_write: cover property (@(posedge CLK) disable iff (!NRST) sec_locked && PS_WR && hit_sec);
  c_count_read: cover property (@(posedge CLK) disable iff (!NRST)
    stop_cnt_q == 4'(TSD_RO_STOP_CYCLES) && PS_RD && hit_cnt0);
  c_dbg_entry:  cover property (@(posedge CLK) disable iff (!NRST) DBG_ENTRY ##1 PS_RD && hit_sts);

endmodule

// ===== core/tsd_pkg.sv
package tsd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register numbers of the processor status space.
  localparam logic [7:0] TSD_REG_BOOT_STATUS  = 8'h03;
  localparam logic [7:0] TSD_REG_SECURITY     = 8'h05;
  localparam logic [7:0] TSD_REG_RO_CONTROL   = 8'h06;
  localparam logic [7:0] TSD_REG_RO_CORE_CELL = 8'h07;
  localparam logic [7:0] TSD_REG_RO_CORE_WIRE = 8'h08;
  localparam logic [7:0] TSD_REG_RO_PERI_CELL = 8'h09;
  localparam logic [7:0] TSD_REG_RO_PERI_WIRE = 8'h0a;
  localparam logic [7:0] TSD_REG_RAM_SIZE     = 8'h0c;
  localparam logic [7:0] TSD_REG_DBG_STATUS   = 8'h10;
  localparam logic [7:0] TSD_REG_DBG_PC       = 8'h11;
  localparam logic [7:0] TSD_REG_DBG_SP       = 8'h12;
  localparam logic [7:0] TSD_REG_DBG_THREAD   = 8'h13;
  localparam logic [7:0] TSD_REG_DBG_REGNUM   = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int TSD_BOOT_PROC_LSB     = 16;
  localparam int TSD_BOOT_OVERRIDE_BIT = 8;
  localparam int TSD_BOOT_CORE1_OFF    = 5;
  localparam int TSD_BOOT_SKIP_POLL    = 4;
  localparam int TSD_BOOT_FROM_RAM     = 3;
  localparam int TSD_BOOT_FROM_JTAG    = 2;
  localparam int TSD_BOOT_PLL_LSB      = 0;
  localparam int TSD_SEC_LOCK_BIT      = 31;
  localparam int TSD_SEC_GDBG_DIS      = 14;
  localparam int TSD_SEC_OTP_LOCK_ALL  = 12;
  localparam int TSD_SEC_OTP_SECT_LSB  = 8;
  localparam int TSD_SEC_OTP_REDUND    = 7;
  localparam int TSD_SEC_OTP_BOOT      = 5;
  localparam int TSD_SEC_JTAG_CFG_DIS  = 4;
  localparam int TSD_SEC_JTAG_TAP_DIS  = 0;
  localparam int TSD_ROC_CORE_EN       = 1;
  localparam int TSD_ROC_PERI_EN       = 0;
  localparam int TSD_STS_ISSUE_MODE    = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Implemented bit masks and reset values.
  localparam logic [31:0] TSD_SEC_MASK     = 32'h8000_5fb1;
  localparam logic [31:0] TSD_ROC_MASK     = 32'h0000_0003;
  localparam logic [31:0] TSD_STS_WR_MASK  = 32'h0000_06df;
  localparam logic [31:0] TSD_STS_CAP_MASK = 32'h0000_07df;
  localparam logic [31:0] TSD_THREAD_MASK  = 32'h0000_00ff;
  localparam logic [31:0] TSD_REGNUM_MASK  = 32'h0000_001f;
  localparam logic [31:0] TSD_RAM_RSV_MASK = 32'h0000_0003;
  localparam logic [31:0] TSD_RST_WORD     = 32'h0000_0000;
  localparam logic [15:0] TSD_RST_COUNT    = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: software waits this many core clocks after a stop before reading.
  localparam int TSD_CLK_PERIOD_NS   = 40;
  localparam int TSD_RO_STOP_CYCLES  = 10;
  localparam int TSD_RO_COUNT        = 4;
  localparam int TSD_RO_WIDTH        = 16;

  typedef enum logic [1:0]
  {
    TSD_ACC_NONE  = 2'b00,
    TSD_ACC_READ  = 2'b01,
    TSD_ACC_WRITE = 2'b10
  } tsd_acc_t;

endpackage

// ===== core/tsd_ro_if.sv
`timescale 1ns/100ps
interface tsd_ro_if;
  logic        core_en;
  logic        peri_en;
  logic [3:0]  tick;
  logic [15:0] count [4];

  modport regs (output core_en, output peri_en, output tick, input count);
  modport osc  (input core_en, input peri_en, input tick, output count);
endinterface

// ===== core/tsd_ring_osc.sv
`timescale 1ns/100ps
module tsd_ring_osc
  import tsd_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  tsd_ro_if.osc    ro
);

  // Index 0 and 1 belong to the core pair, 2 and 3 to the peripheral pair.
  logic [3:0]  tick_q;
  logic [3:0]  run;
  logic [3:0]  step;
  // Counts carry no reset so a system reset leaves them untouched.
  logic [15:0] count_q [4] = '{default: TSD_RST_COUNT};

  assign run  = {ro.peri_en, ro.peri_en, ro.core_en, ro.core_en}; // RL7 RL8
  assign step = run & ro.tick & ~tick_q;                          // RL12

  always_ff @(posedge CLK)
  begin
    if (!NRST)
      tick_q <= 4'h0;
    else
      tick_q <= ro.tick;
  end

  for (genvar i = 0; i < TSD_RO_COUNT; i++)
  begin : g_cnt
    always_ff @(posedge CLK)
    begin
      if (step[i])
        count_q[i] <= count_q[i] + 16'h0001; // RL11
    end
    assign ro.count[i] = count_q[i];
  end

  a_count_frozen: assert property (@(posedge CLK) disable iff (!NRST) // RL7
    !ro.core_en |=> $stable(count_q[0]) && $stable(count_q[1]))
    else $error("core oscillator count moved while stopped");

endmodule

// ===== test/test_tile_status_debug_regs.sv
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_tile_status_debug_regs;
  import tsd_pkg::*;

  logic        CLK = 1'b0;
  logic        NRST = 1'b0;
  logic        PS_RD = 1'b0;
  logic        PS_WR = 1'b0;
  logic [7:0]  PS_ADDR = 8'h00;
  logic [31:0] PS_WDATA = 32'h0;
  logic [31:0] PS_RDATA;
  logic        PS_RVALID;
  logic        PS_ERR;
  logic [7:0]  BOOT_PROC_NUM = 8'h00;
  logic [5:0]  boot_bits = 6'h00;
  logic [1:0]  BOOT_PLL_MODE = 2'h0;
  logic        OTP_SEC_VALID = 1'b0;
  logic [31:0] OTP_SEC_WORD = 32'h0;
  logic [3:0]  RO_TICK = 4'h0;
  logic        DBG_MODE = 1'b0;
  logic        DBG_ENTRY = 1'b0;
  logic [31:0] THREAD_SR = 32'h0;
  logic [31:0] THREAD_PC = 32'h0;
  logic [31:0] THREAD_SP = 32'h0;
  wire  [11:0] sec_out;
  logic        RO_CORE_EN;
  logic        RO_PERI_EN;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [31:0] rng;
  logic [31:0] boot_w;
  logic [31:0] w;
  logic [15:0] cnt [4] = '{default: 16'h0000};
  logic [33:0] notes [$];
  logic [33:0] note;

  always #20 CLK = ~CLK;

  tsd_regs i_dut (
    .CLK(CLK), .NRST(NRST), .PS_RD(PS_RD), .PS_WR(PS_WR), .PS_ADDR(PS_ADDR), .PS_WDATA(PS_WDATA),
    .PS_RDATA(PS_RDATA), .PS_RVALID(PS_RVALID), .PS_ERR(PS_ERR), .BOOT_PROC_NUM(BOOT_PROC_NUM),
    .BOOT_OVERRIDE(boot_bits[5]), .BOOT_CORE1_OFF(boot_bits[4]), .BOOT_SKIP_POLL(boot_bits[3]),
    .BOOT_FROM_RAM(boot_bits[2]), .BOOT_FROM_JTAG(boot_bits[1]), .BOOT_PLL_MODE(BOOT_PLL_MODE),
    .OTP_SEC_VALID(OTP_SEC_VALID), .OTP_SEC_WORD(OTP_SEC_WORD), .RO_TICK(RO_TICK), .DBG_MODE(DBG_MODE),
    .DBG_ENTRY(DBG_ENTRY), .THREAD_SR(THREAD_SR), .THREAD_PC(THREAD_PC), .THREAD_SP(THREAD_SP),
    .SEC_LOCKED(sec_out[11]), .DBG_GLOBAL_DIS(sec_out[10]), .JTAG_CFG_DIS(sec_out[9]),
    .JTAG_TAP_DIS(sec_out[8]), .OTP_LOCK_ALL(sec_out[7]), .OTP_SECTOR_LOCK(sec_out[6:3]),
    .OTP_REDUNDANCY_EN(sec_out[2]), .OTP_BOOT_OVERRIDE(sec_out[1]), .RO_CORE_EN(RO_CORE_EN),
    .RO_PERI_EN(RO_PERI_EN)
  );
  assign sec_out[0] = 1'b0;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Each task call is taken at the next rising edge; the caller lowers the strobes with idle.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic er);
    PS_RD = 1'b1;
    PS_WR = 1'b0;
    PS_ADDR = a;
    notes.push_back({1'b1, er, exp});
    @(negedge CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic er);
    PS_RD = 1'b0;
    PS_WR = 1'b1;
    PS_ADDR = a;
    PS_WDATA = d;
    if (er)
    begin
      notes.push_back({1'b0, 1'b1, 32'h0});
    end
    @(negedge CLK);
  endtask

  task automatic idle(input int n);
    PS_RD = 1'b0;
    PS_WR = 1'b0;
    repeat (n) @(negedge CLK);
  endtask

  task automatic otp_load(input logic [31:0] d);
    OTP_SEC_WORD = d;
    OTP_SEC_VALID = 1'b1;
    @(negedge CLK);
    OTP_SEC_VALID = 1'b0;
    @(negedge CLK);
    w = d & TSD_SEC_MASK;
    `CHK(sec_out, {w[31], w[14], w[4], w[0], w[12], w[11:8], w[7], w[5], 1'b0})
    rd(TSD_REG_SECURITY, w, 1'b0);
  endtask

  // Counts change only while the lane's enable is stable; ticks settle before the stop write.
  task automatic tick_run(input logic [1:0] en);
    idle(0);
    repeat (6)
    begin
      rng = xs(rng);
      RO_TICK = rng[3:0];
      repeat (3) @(negedge CLK);
      RO_TICK = 4'h0;
      repeat (3) @(negedge CLK);
      for (int i = 0; i < 4; i++)
      begin
        if (rng[i] && en[i < 2])
        begin
          cnt[i] = cnt[i] + 16'h0001;
        end
      end
    end
  endtask

  task automatic rd_counts();
    for (int i = 0; i < 4; i++)
    begin
      rd(TSD_REG_RO_CORE_CELL + 8'(i), {16'h0000, cnt[i]}, 1'b0);
    end
    idle(1);
  endtask

  task automatic finish_test();
    if (n_errors == 0 && num_checks > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read data is only meaningful while valid, so it is masked before the compare.
  always @(negedge CLK)
  begin
    if (PS_RVALID === 1'b1 || PS_ERR === 1'b1)
    begin
      if (notes.size() == 0)
      begin
        `CHK(1'b1, 1'b0)
      end
      else
      begin
        note = notes.pop_front();
        `CHK({PS_RVALID, PS_ERR, PS_RVALID ? PS_RDATA : 32'h0}, note)
      end
    end
  end

  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_errors++;
      finish_test();
    end
  end

  initial
  begin
    rng = 32'hd796;
    rng = xs(rng);
    {BOOT_PROC_NUM, boot_bits, BOOT_PLL_MODE} = rng[15:0];
    boot_w = {8'h00, BOOT_PROC_NUM, 7'h00, boot_bits[5], 2'b00, boot_bits[4:1], BOOT_PLL_MODE};
    repeat (8) @(negedge CLK);
    NRST = 1'b1;
    idle(2);
    rd(TSD_REG_RO_CONTROL, 32'h0, 1'b0);
    rd(TSD_REG_SECURITY, 32'h0, 1'b0);
    rd(TSD_REG_BOOT_STATUS, boot_w, 1'b0);
    wr(TSD_REG_BOOT_STATUS, 32'hffff_ffff, 1'b1);
    rd(TSD_REG_BOOT_STATUS, boot_w, 1'b0);
    rd(8'h04, 32'h0, 1'b1);
    wr(TSD_REG_RAM_SIZE, 32'h0, 1'b1);
    rd(TSD_REG_RAM_SIZE, 32'h0001_0000 & ~TSD_RAM_RSV_MASK, 1'b0);
    idle(1);
    rng = xs(rng);
    otp_load(rng & 32'h7fff_ffff);
    wr(TSD_REG_SECURITY, 32'h7fff_ffff, 1'b0);
    rd(TSD_REG_SECURITY, 32'h7fff_ffff & TSD_SEC_MASK, 1'b0);
    wr(TSD_REG_SECURITY, 32'h8000_1234, 1'b0);
    wr(TSD_REG_SECURITY, 32'h0000_0001, 1'b1);
    rd(TSD_REG_SECURITY, 32'h8000_1234 & TSD_SEC_MASK, 1'b0);
    idle(1);
    otp_load(32'h0000_5fb1);
    idle(1);
    for (int e = 1; e < 4; e++)
    begin
      wr(TSD_REG_RO_CONTROL, 32'hffff_fff0 | 32'(e), 1'b0);
      rd(TSD_REG_RO_CONTROL, 32'(e), 1'b0);
      idle(1);
      `CHK({RO_CORE_EN, RO_PERI_EN}, 2'(e))
      tick_run(2'(e));
      idle(10);
      wr(TSD_REG_RO_CONTROL, 32'h0, 1'b0);
      tick_run(2'b00);
      idle(TSD_RO_STOP_CYCLES);
      rd_counts();
    end
    NRST = 1'b0;
    repeat (8) @(negedge CLK);
    NRST = 1'b1;
    idle(2);
    rd(TSD_REG_RO_CONTROL, 32'h0, 1'b0);
    rd_counts();
    rng = xs(rng);
    THREAD_SR = rng;
    THREAD_PC = xs(rng);
    THREAD_SP = ~rng;
    DBG_ENTRY = 1'b1;
    @(negedge CLK);
    DBG_ENTRY = 1'b0;
    rd(TSD_REG_DBG_STATUS, THREAD_SR & TSD_STS_CAP_MASK, 1'b0);
    rd(TSD_REG_DBG_PC, THREAD_PC, 1'b0);
    rd(TSD_REG_DBG_SP, THREAD_SP, 1'b0);
    wr(TSD_REG_DBG_PC, 32'h0, 1'b1);
    wr(TSD_REG_DBG_THREAD, 32'h0, 1'b1);
    rd(TSD_REG_DBG_PC, THREAD_PC, 1'b0);
    idle(1);
    DBG_MODE = 1'b1;
    w = THREAD_SR & 32'h0000_0100;
    wr(TSD_REG_DBG_STATUS, 32'hffff_ffff, 1'b0);
    rd(TSD_REG_DBG_STATUS, TSD_STS_WR_MASK | w, 1'b0);
    wr(TSD_REG_DBG_PC, THREAD_SP, 1'b0);
    wr(TSD_REG_DBG_SP, THREAD_PC, 1'b0);
    wr(TSD_REG_DBG_THREAD, 32'hffff_ffff, 1'b0);
    wr(TSD_REG_DBG_REGNUM, 32'hffff_ffff, 1'b0);
    rd(TSD_REG_DBG_PC, THREAD_SP, 1'b0);
    rd(TSD_REG_DBG_SP, THREAD_PC, 1'b0);
    rd(TSD_REG_DBG_THREAD, TSD_THREAD_MASK, 1'b0);
    rd(TSD_REG_DBG_REGNUM, TSD_REGNUM_MASK, 1'b0);
    DBG_ENTRY = 1'b1;
    wr(TSD_REG_DBG_PC, 32'h0, 1'b0);
    DBG_ENTRY = 1'b0;
    rd(TSD_REG_DBG_PC, THREAD_PC, 1'b0);
    idle(4);
    `CHK(notes.size(), 0)
    finish_test();
  end
endmodule
